//--- wrs_pkg.sv
// Package: register map, field positions and reset values of the block
`default_nettype none

package wrs_pkg;

    // ------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RX_QUEUE_CONTROL     = 8'h82;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE     = 8'h90;
    localparam logic [7:0] OFS_INTERRUPT_STATUS     = 8'h92;
    localparam logic [7:0] OFS_RX_FRAME_COUNT_THR   = 8'h9C;
    localparam logic [7:0] OFS_POWER_MGMT_CONTROL   = 8'hD4;

    // ------------------------------------------------------------
    // Interrupt status bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_RX_INT          = 13;
    localparam int unsigned BIT_RX_STOPPED      = 8;
    localparam int unsigned BIT_TX_SPACE        = 6;
    localparam int unsigned BIT_WAKEUP_FRAME    = 5;
    localparam int unsigned BIT_MAGIC_PACKET    = 4;
    localparam int unsigned BIT_LINKUP          = 3;
    localparam int unsigned BIT_ENERGY          = 2;

    // Implemented status bits, write-one-to-clear bits, reset value
    localparam logic [15:0] STAT_IMPL_MASK = 16'h217C;
    localparam logic [15:0] STAT_W1C_MASK  = 16'h2140;
    localparam logic [15:0] STAT_RST       = 16'h0100;

    // ------------------------------------------------------------
    // Interrupt enable fields
    // ------------------------------------------------------------
    localparam logic [15:0] IE_WMASK        = 16'h217D;
    localparam logic [15:0] IE_RST          = 16'h0000;
    localparam int unsigned IE_BIT_ENERGY   = 2;
    localparam int unsigned IE_BIT_DELAYED  = 0;

    // ------------------------------------------------------------
    // Power management control: wake status clear field [5:2]
    // ------------------------------------------------------------
    localparam logic [15:0] PMC_WMASK    = 16'h003C;
    localparam logic [15:0] PMC_RST      = 16'h0000;
    localparam int unsigned PMC_CLR_LSB  = 2;
    localparam logic [3:0]  PMC_CLR_WAKE_FRAME = 4'h8;
    localparam logic [3:0]  PMC_CLR_MAGIC      = 4'h4;
    localparam logic [3:0]  PMC_CLR_LINKUP     = 4'h2;
    localparam logic [3:0]  PMC_CLR_ENERGY     = 4'h1;

    // ------------------------------------------------------------
    // Receive queue control and frame count register
    // ------------------------------------------------------------
    localparam int unsigned RXQC_BIT_THR_EN = 5;
    localparam logic        RXQC_THR_EN_RST = 1'b0;
    localparam int unsigned FC_CNT_LSB      = 8;
    localparam int unsigned FC_THR_LSB      = 0;
    localparam logic [7:0]  FC_CNT_RST      = 8'h00;
    localparam logic [7:0]  FC_THR_RST      = 8'h00;

endpackage : wrs_pkg

`default_nettype wire

//--- wrs_sticky_bit.sv
// Sticky status flag: hardware set wins over software clear
`default_nettype none

module wrs_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Set and clear requests
    input  wire logic set_i,
    input  wire logic clr_i,
    // Flag
    output var  logic q_o
);

    logic next_q;

    // An event in the clearing cycle must not be lost
    assign next_q = set_i ? 1'b1 : (clr_i ? 1'b0 : q_o);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_o <= RST_VAL;
        end else begin
            q_o <= next_q;
        end
    end

endmodule : wrs_sticky_bit

`default_nettype wire

//--- wrs_frame_tracker.sv
// Receive queue frame counter with threshold compare and snapshot
`default_nettype none

module wrs_frame_tracker (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Queue events
    input  wire logic       frame_in_i,
    input  wire logic       frame_out_i,
    // Configuration
    input  wire logic       thr_en_i,
    input  wire logic [7:0] thr_i,
    // Results
    output logic            rx_event_o,
    output logic [7:0]      count_snap_o
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       meets_q;
    logic       next_meets;
    logic       inc;
    logic       dec;
    logic       next_event;

    // Counter saturates instead of wrapping
    assign inc = frame_in_i && !frame_out_i && (cnt != 8'hFF);
    assign dec = frame_out_i && !frame_in_i && (cnt != 8'h00);
    assign next_cnt = inc ? cnt + 8'h01 : (dec ? cnt - 8'h01 : cnt);

    assign next_meets = thr_en_i ? (next_cnt >= thr_i)
                                 : (next_cnt != 8'h00);
    // Rising edge of the condition; each new frame also counts without
    // threshold mode
    assign next_event = (next_meets && !meets_q)
                      || (!thr_en_i && frame_in_i);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt          <= 8'h00;
            meets_q      <= 1'b0;
            rx_event_o   <= 1'b0;
            count_snap_o <= wrs_pkg::FC_CNT_RST;
        end else begin
            cnt        <= next_cnt;
            meets_q    <= next_meets;
            rx_event_o <= next_event;
            if (next_event) begin
                count_snap_o <= next_cnt;
            end
        end
    end

endmodule : wrs_frame_tracker

`default_nettype wire

//--- wrs_top.sv
// Wake-up and receive interrupt status block with frame count register
//
// Summary of operation
// - Bit 8 flags halted reception, resets one
// - Bit 8 cleared only by writing one
// - Bit 6 set when transmit space frees
// - Bit 5 cleared by clear code 1000
// - Bit 4 cleared by clear code 0100
// - Bit 3 cleared by clear code 0010
// - Bit 2 set per energy enable bits
// - Bit 2 cleared by clear code 0001
// - Frame count snapshot on receive interrupt
// - Threshold field read-write, resets zero
// - Threshold mode: set bit 13 at count
// - Interrupt when enabled status bit set
// - Bit 13 set when frame queued, outside threshold mode
//
// Decided for this implementation: the strobed register port.
`default_nettype none

module wrs_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    // Event sources from device logic
    input  wire logic        rx_halted_i,
    input  wire logic        tx_space_free_i,
    input  wire logic        wakeup_frame_i,
    input  wire logic        magic_packet_i,
    input  wire logic        linkup_i,
    input  wire logic        energy_i,
    input  wire logic        delayed_energy_i,
    // Receive queue events
    input  wire logic        rx_frame_in_i,
    input  wire logic        rx_frame_out_i,
    // Interrupt
    output logic             irq_o
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic sel_status;
    logic sel_enable;
    logic sel_fc;
    logic sel_pmc;
    logic sel_rxqc;
    logic wr_status;
    logic wr_enable;
    logic wr_fc;
    logic wr_pmc;
    logic wr_rxqc;

    // Full address compare: aliases of unused offsets must read zero
    assign sel_status = (addr_i == wrs_pkg::OFS_INTERRUPT_STATUS);
    assign sel_enable = (addr_i == wrs_pkg::OFS_INTERRUPT_ENABLE);
    assign sel_fc     = (addr_i == wrs_pkg::OFS_RX_FRAME_COUNT_THR);
    assign sel_pmc    = (addr_i == wrs_pkg::OFS_POWER_MGMT_CONTROL);
    assign sel_rxqc   = (addr_i == wrs_pkg::OFS_RX_QUEUE_CONTROL);

    assign wr_status = wr_i && sel_status;
    assign wr_enable = wr_i && sel_enable;
    assign wr_fc     = wr_i && sel_fc;
    assign wr_pmc    = wr_i && sel_pmc;
    assign wr_rxqc   = wr_i && sel_rxqc;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [15:0] int_enable;
    logic [15:0] pmc;
    logic        thr_en;
    logic [7:0]  rx_frame_threshold;
    logic [15:0] next_int_enable;
    logic [15:0] next_pmc;
    logic        next_thr_en;
    logic [7:0]  next_rx_frame_threshold;

    // Writable fields are masked so read-only bits never take a value;
    // enable bits 1 and 7 are reserved and stay zero
    assign next_int_enable = wr_enable ? (wdata_i & wrs_pkg::IE_WMASK)
                                       : int_enable;
    assign next_pmc        = wr_pmc ? (wdata_i & wrs_pkg::PMC_WMASK)
                                    : pmc;
    assign next_thr_en     = wr_rxqc ? wdata_i[wrs_pkg::RXQC_BIT_THR_EN]
                                     : thr_en;
    // Count half is read-only; only the threshold lands
    assign next_rx_frame_threshold =
        wr_fc ? wdata_i[wrs_pkg::FC_THR_LSB +: 8] : rx_frame_threshold;

    // One short process per register keeps each reset value in sight
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            int_enable <= wrs_pkg::IE_RST;
        end else begin
            int_enable <= next_int_enable;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pmc <= wrs_pkg::PMC_RST;
        end else begin
            pmc <= next_pmc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            thr_en <= wrs_pkg::RXQC_THR_EN_RST;
        end else begin
            thr_en <= next_thr_en;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_frame_threshold <= wrs_pkg::FC_THR_RST;
        end else begin
            rx_frame_threshold <= next_rx_frame_threshold;
        end
    end

    // ------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------
    logic       halted_q;
    logic       halted_rise;
    logic       ie_energy;
    logic       ie_delayed;
    logic       energy_set;
    logic [3:0] pmc_code;
    logic       rx_event;

    // Status is edge-triggered: a lasting halt sets it once only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            halted_q <= 1'b1;
        end else begin
            halted_q <= rx_halted_i;
        end
    end

    assign halted_rise = rx_halted_i && !halted_q;

    // Energy sources are gated at set time; changing the enables later
    // does not rewrite a flag that is already up
    assign ie_energy  = int_enable[wrs_pkg::IE_BIT_ENERGY];
    assign ie_delayed = int_enable[wrs_pkg::IE_BIT_DELAYED];
    assign energy_set = (energy_i && ie_energy && !ie_delayed)
                      || (delayed_energy_i && ie_energy && ie_delayed);

    assign pmc_code = wdata_i[wrs_pkg::PMC_CLR_LSB +: 4];

    // ------------------------------------------------------------
    // Set and clear vectors
    // ------------------------------------------------------------
    logic [15:0] stat_set;
    logic [15:0] stat_clr;
    logic [15:0] w1c_clr;
    logic [15:0] pmc_clr;

    // Writing zero leaves a bit alone; reserved bits take no effect
    assign w1c_clr = wr_status ? (wdata_i & wrs_pkg::STAT_W1C_MASK)
                               : 16'h0000;

    // Only the four exact codes clear; any other pattern clears nothing
    logic clr_wake_frame;
    logic clr_magic;
    logic clr_linkup;
    logic clr_energy;

    assign clr_wake_frame = wr_pmc
                         && (pmc_code == wrs_pkg::PMC_CLR_WAKE_FRAME);
    assign clr_magic      = wr_pmc
                         && (pmc_code == wrs_pkg::PMC_CLR_MAGIC);
    assign clr_linkup     = wr_pmc
                         && (pmc_code == wrs_pkg::PMC_CLR_LINKUP);
    assign clr_energy     = wr_pmc
                         && (pmc_code == wrs_pkg::PMC_CLR_ENERGY);

    always_comb begin
        pmc_clr = 16'h0000;
        pmc_clr[wrs_pkg::BIT_WAKEUP_FRAME] = clr_wake_frame;
        pmc_clr[wrs_pkg::BIT_MAGIC_PACKET] = clr_magic;
        pmc_clr[wrs_pkg::BIT_LINKUP]       = clr_linkup;
        pmc_clr[wrs_pkg::BIT_ENERGY]       = clr_energy;
    end

    // Set and clear meet in the flag, where set takes priority
    assign stat_clr = w1c_clr | pmc_clr;

    always_comb begin
        stat_set = 16'h0000;
        stat_set[wrs_pkg::BIT_RX_INT]       = rx_event;
        stat_set[wrs_pkg::BIT_RX_STOPPED]   = halted_rise;
        stat_set[wrs_pkg::BIT_TX_SPACE]     = tx_space_free_i;
        stat_set[wrs_pkg::BIT_WAKEUP_FRAME] = wakeup_frame_i;
        stat_set[wrs_pkg::BIT_MAGIC_PACKET] = magic_packet_i;
        stat_set[wrs_pkg::BIT_LINKUP]       = linkup_i;
        stat_set[wrs_pkg::BIT_ENERGY]       = energy_set;
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic [15:0] interrupt_status;

    // Reserved positions are tied off, so writes there cannot stick
    for (genvar i = 0; i < 16; i++) begin : g_stat
        if (wrs_pkg::STAT_IMPL_MASK[i]) begin : g_impl
            wrs_sticky_bit #(
                .RST_VAL (wrs_pkg::STAT_RST[i])
            ) u_flag (
                .clk_i  (clk_i),
                .srst_i (srst_i),
                .set_i  (stat_set[i]),
                .clr_i  (stat_clr[i]),
                .q_o    (interrupt_status[i])
            );
        end else begin : g_rsvd
            assign interrupt_status[i] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive frame counting
    // ------------------------------------------------------------
    logic [7:0] rx_frame_count;

    // A zero threshold in threshold mode is the host's to avoid; here
    // it simply makes the condition true at once.
    wrs_frame_tracker u_frames (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .frame_in_i   (rx_frame_in_i),
        .frame_out_i  (rx_frame_out_i),
        .thr_en_i     (thr_en),
        .thr_i        (rx_frame_threshold),
        .rx_event_o   (rx_event),
        .count_snap_o (rx_frame_count)
    );

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    logic next_irq;

    // Registered so the pin never glitches while flags and enables settle
    assign next_irq = |(interrupt_status & int_enable);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    logic [15:0] fc_word;
    logic [15:0] rxqc_word;
    logic [15:0] next_rdata;

    // Reads have no side effect: flags clear only by explicit writes
    assign fc_word = {rx_frame_count, rx_frame_threshold};
    always_comb begin
        rxqc_word = 16'h0000;
        rxqc_word[wrs_pkg::RXQC_BIT_THR_EN] = thr_en;
    end

    // Unmapped addresses read as zero
    assign rd_mux = sel_status ? interrupt_status
                  : sel_enable ? int_enable
                  : sel_fc     ? fc_word
                  : sel_pmc    ? pmc
                  : sel_rxqc   ? rxqc_word
                  : 16'h0000;

    // Data stands only in the cycle after the read strobe
    assign next_rdata = rd_i ? rd_mux : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule : wrs_top

`default_nettype wire

//--- wrs_top_properties.sv
// Checker for the register port and interrupt of wrs_top
`default_nettype none

module wrs_props (
    // Clock, reset and register port
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    // Event sources and interrupt
    input wire logic        rx_halted_i,
    input wire logic        tx_space_free_i,
    input wire logic        wakeup_frame_i,
    input wire logic        magic_packet_i,
    input wire logic        linkup_i,
    input wire logic        energy_i,
    input wire logic        delayed_energy_i,
    input wire logic        rx_frame_in_i,
    input wire logic        rx_frame_out_i,
    input wire logic        irq_o
);
    // ------------------------------------------------------------
    // Shadows rebuilt from bus writes
    // ------------------------------------------------------------
    wire         en_wr  = wr_i && addr_i == 8'h90;
    wire         st_wr  = wr_i && addr_i == 8'h92;
    wire         pmc_wr = wr_i && addr_i == 8'hD4;
    wire         st_rd  = rd_i && addr_i == 8'h92;
    wire         thr_rd = rd_i && addr_i == 8'h9C;
    logic [15:0] en;
    logic [7:0]  thr;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            en  <= 16'h0000;
            thr <= 8'h00;
        end else begin
            if (en_wr) en <= wdata_i & wrs_pkg::IE_WMASK;
            if (wr_i && addr_i == 8'h9C) thr <= wdata_i[7:0];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero when idle");
    a_reserved_zero: assert property (st_rd |=>
        (rdata_o & ~wrs_pkg::STAT_IMPL_MASK) == 16'h0000)
        else $error("reserved status bit set");
    a_halt_sets: assert property ($rose(rx_halted_i) &&
        !$past(srst_i) ##1 !(st_wr && wdata_i[8]) ##1 st_rd |=> rdata_o[8])
        else $error("halt edge did not set status");
    a_halt_w1c: assert property (st_wr && wdata_i[8] &&
        !$rose(rx_halted_i) ##1 !$rose(rx_halted_i) ##1 st_rd
        |=> !rdata_o[8]) else $error("halt status not cleared");
    a_wake_clear: assert property (pmc_wr && wdata_i[5:2] == 4'h8 &&
        !wakeup_frame_i ##1 !wakeup_frame_i ##1 st_rd |=> !rdata_o[5])
        else $error("wake frame status not cleared");
    a_thr_readback: assert property (thr_rd |=>
        rdata_o[7:0] == thr) else $error("threshold readback wrong");
    a_linkup_irq: assert property (linkup_i && en[3] && !en_wr
        |-> ##2 irq_o) else $error("linkup did not raise irq");
    a_energy_gate: assert property (energy_i && en[2] && !en[0] &&
        !en_wr |-> ##2 irq_o) else $error("energy did not raise irq");
endmodule : wrs_props

bind wrs_top wrs_props u_props (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_halted_i(rx_halted_i), .tx_space_free_i(tx_space_free_i),
    .wakeup_frame_i(wakeup_frame_i), .magic_packet_i(magic_packet_i),
    .linkup_i(linkup_i), .energy_i(energy_i),
    .delayed_energy_i(delayed_energy_i), .rx_frame_in_i(rx_frame_in_i),
    .rx_frame_out_i(rx_frame_out_i), .irq_o(irq_o)
);

`default_nettype wire

//--- wrs_host.sv
// Host processor model driving the register port
`default_nettype none

module wrs_host (
    // Clock
    input  wire logic        clk_i,
    // Register port
    output logic      [7:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o,
    input  wire logic [15:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr_o  = 8'h00;
        wdata_o = 16'h0000;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask : rd_reg
endmodule : wrs_host

`default_nettype wire

//--- wrs_top_tb.sv
// Self-checking testbench for wrs_top
`default_nettype none

module wrs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        irq;
    logic [8:0]  ev = 9'h000;
    logic [15:0] st = 16'h0100;
    logic [15:0] en = 16'h0000;
    logic [31:0] seed = 32'h0000D395;
    logic [31:0] r;
    logic [15:0] got;
    logic [3:0]  c;
    int          num_errors = 0;
    int          n_tests = 0;
    int          t;

    always #2 clk_i = ~clk_i;

    wrs_host u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

    wrs_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .rx_halted_i(ev[0]), .tx_space_free_i(ev[1]),
        .wakeup_frame_i(ev[2]), .magic_packet_i(ev[3]), .linkup_i(ev[4]),
        .energy_i(ev[5]), .delayed_energy_i(ev[6]),
        .rx_frame_in_i(ev[7]), .rx_frame_out_i(ev[8]), .irq_o(irq));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Status bit raised by event source k under the current enables
    function automatic logic [15:0] set_mask(input int k);
        case (k)
            0: return 16'h0100;
            1: return 16'h0040;
            2: return 16'h0020;
            3: return 16'h0010;
            4: return 16'h0008;
            5: return (en[2] && !en[0]) ? 16'h0004 : 16'h0000;
            default: return (en[2] && en[0]) ? 16'h0004 : 16'h0000;
        endcase
    endfunction : set_mask

    function automatic logic [15:0] pmc_mask(input logic [3:0] k);
        case (k)
            4'h8: return 16'h0020;
            4'h4: return 16'h0010;
            4'h2: return 16'h0008;
            4'h1: return 16'h0004;
            default: return 16'h0000;
        endcase
    endfunction : pmc_mask

    task automatic chk(input logic [15:0] g, e, input string m);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic wr_m(input logic [7:0] a, input logic [15:0] d);
        u_host.wr_reg(a, d);
        if (a == 8'h92) st = st & ~(d & wrs_pkg::STAT_W1C_MASK);
        if (a == 8'hD4) st = st & ~pmc_mask(d[5:2]);
        if (a == 8'h90) en = d & wrs_pkg::IE_WMASK;
    endtask : wr_m

    task automatic rd_c(input logic [7:0] a, input logic [15:0] e,
                        input string m);
        u_host.rd_reg(a, got);
        chk(got, e, m);
    endtask : rd_c

    task automatic fire(input int k);
        @(posedge clk_i);
        ev[k] <= 1'b1;
        @(posedge clk_i);
        ev[k] <= 1'b0;
        if (k < 7) st = st | set_mask(k);
    endtask : fire

    task automatic test_done;
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #40000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_c(8'h92, 16'h0100, "status reset");
        rd_c(8'h9C, 16'h0000, "count reset");
        wr_m(8'h92, 16'h0000);
        rd_c(8'h92, 16'h0100, "zero write");
        wr_m(8'h92, 16'hFFFF);
        rd_c(8'h92, 16'h0000, "clear all");
        // A halt level held high must not re-set after a clear
        @(posedge clk_i);
        ev[0] <= 1'b1;
        rd_c(8'h92, 16'h0100, "halt set");
        wr_m(8'h92, 16'h0100);
        rd_c(8'h92, 16'h0000, "halt held");
        ev[0] <= 1'b0;
        wr_m(8'h94, 16'hFFFF);
        rd_c(8'h94, 16'h0000, "unmapped");
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            c = r[4] ? r[19:16] : 4'h1 << r[3:2];
            case (r[6:5])
                2'h0: wr_m(8'h90, r[31:16]);
                2'h1: wr_m(8'hD4, {10'h000, c, 2'h0});
                2'h2: wr_m(8'h92, r[31:16]);
                default: fire(int'(r[10:8] % 3'h7));
            endcase
            fire(int'(r[14:12] % 3'h7));
            rd_c(8'h92, st, "status");
            chk({15'h0000, irq}, {15'h0000, |(st & en)}, "irq");
        end
        rd_c(8'h90, en, "enable");
        fire(2);
        wr_m(8'hD4, 16'h0020);
        rd_c(8'h92, st, "wake clear");
        rd_c(8'hD4, 16'h0020, "power control");
        fire(7);
        repeat (3) @(posedge clk_i);
        st = st | 16'h2000;
        rd_c(8'h92, st, "rx flag");
        wr_m(8'h92, 16'h2000);
        st = st & 16'hDFFF;
        rd_c(8'h9C, 16'h0100, "count");
        fire(8);
        r = rnd();
        t = 2 + int'(r[1:0]);
        wr_m(8'h9C, 16'(t));
        wr_m(8'h82, 16'h0020);
        rd_c(8'h82, 16'h0020, "queue mode");
        rd_c(8'h9C, {8'h01, 8'(t)}, "threshold");
        for (int k = 1; k <= t; k++) begin
            fire(7);
            repeat (3) @(posedge clk_i);
            if (k == t) st = st | 16'h2000;
            rd_c(8'h92, st, "threshold flag");
        end
        rd_c(8'h9C, {8'(t), 8'(t)}, "count at threshold");
        test_done();
    end
endmodule : wrs_top_tb

`default_nettype wire
